// ==== hdl/lotp_top.sv ====
/*
 lotp_top: serial lane formatter with test patterns, bit and frame clocks,
 register file and power-up strap capture.
 assumes link_clk runs at six ticks per data bit, the register port is
 decoded by a serial port block on ref_clk, and sample_data is produced on
 link_clk and held stable around sample_take.
*/
// How it works
// - bit clock phase steps of 60 degrees
// - default bit clock edge mid data bit
// - word length selectable 8, 10, 12 or 14 bits
// - 14-bit conversion data words add two trailing zeros, pattern words do not
// - invert option flips every data bit
// - msb first default, lsb first option
// - twelve test patterns replace conversion data
// - two-word patterns alternate, prbs patterns run free, others repeat
// - user pattern from bytes user_pattern_byte_a to user_pattern_byte_d
// - format conversion only for some patterns
// - patterns except prbs and the strap pattern follow word length
// - prbs9 seed 0x0df, period 511
// - prbs23 seed 0x29b80a, period 8388607
// - prbs23 stream inverted
// - port select and swing strap high selects reduced swing
// - reduced swing keeps timing and content
// - pattern strap forces 1000 0000 0000
// - port select high ignores register writes
// - four-bit test mode code
// - bit clock half word length times frame, ddr launch
// - offset binary default, twos complement option
`timescale 1ns/1ps
module lotp_top #(
   parameter int LANES = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic port_select_n,
   input wire logic serial_data_or_swing_pin,
   input wire logic serial_clock_or_pattern_pin,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   output logic reduced_swing,
   input wire logic [LANES*lotp_pkg::DATA_W-1:0] sample_data,
   output logic sample_take,
   output logic [LANES-1:0] data_out,
   output logic frame_clock_out,
   output logic bit_clock_out
);
   import lotp_pkg::*;
   localparam int CFG_W = 45;
   // register side
   logic [2:0] pin_s1_reg, pin_s2_reg;
   logic [3:0] mode_reg;
   logic [7:0] out_mode_reg, phase_reg, res_reg;
   logic [7:0] user_a_reg, user_b_reg, user_c_reg, user_d_reg;
   logic [1:0] strap_cnt_reg;
   logic strap_done_reg, swing_reg, strap_pat_reg;
   logic [CFG_W-1:0] cfg_sent_reg;
   logic req_reg, ack_s1_reg, ack_s2_reg, ack_link_reg;
   wire cs_high = pin_s2_reg[2];
   wire wr_ok = reg_wr_en & ~cs_high;
   wire wr_mode = wr_ok & (reg_addr == REG_TEST_MODE);
   wire wr_out = wr_ok & (reg_addr == REG_OUT_MODE);
   wire wr_phase = wr_ok & (reg_addr == REG_PHASE);
   wire wr_res = wr_ok & (reg_addr == REG_RES);
   wire wr_ua = wr_ok & (reg_addr == REG_USER_A);
   wire wr_ub = wr_ok & (reg_addr == REG_USER_B);
   wire wr_uc = wr_ok & (reg_addr == REG_USER_C);
   wire wr_ud = wr_ok & (reg_addr == REG_USER_D);
   wire cfg_busy = req_reg ^ ack_s2_reg;
   wire [CFG_W-1:0] cfg_now = {strap_pat_reg, res_reg[RES_LSB_FIRST_BIT],
      res_reg[1:0], phase_reg[2:0], out_mode_reg[OUT_MODE_INV_BIT],
      out_mode_reg[OUT_MODE_TWOS_BIT], mode_reg,
      user_a_reg, user_b_reg, user_c_reg, user_d_reg};
   wire cfg_send = ~cfg_busy & (cfg_now != cfg_sent_reg);
   wire [7:0] status_val = {5'h00, cfg_busy, strap_pat_reg, swing_reg};
   wire [7:0] rd_next = (reg_addr == REG_STATUS) ? status_val :
      (reg_addr == REG_TEST_MODE) ? {4'h0, mode_reg} :
      (reg_addr == REG_OUT_MODE) ? out_mode_reg :
      (reg_addr == REG_PHASE) ? phase_reg :
      (reg_addr == REG_RES) ? res_reg :
      (reg_addr == REG_USER_A) ? user_a_reg :
      (reg_addr == REG_USER_B) ? user_b_reg :
      (reg_addr == REG_USER_C) ? user_c_reg :
      (reg_addr == REG_USER_D) ? user_d_reg : 8'h00;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         reg_rd_data <= 8'h00;
      end
      else
      begin
         pin_s1_reg <= {port_select_n, serial_data_or_swing_pin,
            serial_clock_or_pattern_pin};
         pin_s2_reg <= pin_s1_reg;
         ack_s1_reg <= ack_link_reg;
         ack_s2_reg <= ack_s1_reg;
         reg_rd_data <= rd_next;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_reg <= TEST_MODE_RST;
         out_mode_reg <= 8'h00;
         phase_reg <= {5'h00, PHASE_RST};
         res_reg <= {6'h00, RES_RST};
         user_a_reg <= USER_RST;
         user_b_reg <= USER_RST;
         user_c_reg <= USER_RST;
         user_d_reg <= USER_RST;
      end
      else
      begin
         if (wr_mode) mode_reg <= reg_wr_data[3:0];
         if (wr_out) out_mode_reg <= reg_wr_data;
         if (wr_phase) phase_reg <= reg_wr_data;
         if (wr_res) res_reg <= reg_wr_data;
         if (wr_ua) user_a_reg <= reg_wr_data;
         if (wr_ub) user_b_reg <= reg_wr_data;
         if (wr_uc) user_c_reg <= reg_wr_data;
         if (wr_ud) user_d_reg <= reg_wr_data;
      end
   end

   // strap capture once after release, then configuration handshake
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         strap_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         swing_reg <= 1'b0;
         strap_pat_reg <= 1'b0;
         reduced_swing <= 1'b0;
         cfg_sent_reg <= '0;
         req_reg <= 1'b0;
      end
      else
      begin
         if (!strap_done_reg)
         begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == STRAP_DLY)
            begin
               strap_done_reg <= 1'b1;
               swing_reg <= pin_s2_reg[2] & pin_s2_reg[1];
               strap_pat_reg <= pin_s2_reg[2] & pin_s2_reg[0];
            end
         end
         reduced_swing <= swing_reg;
         if (cfg_send)
         begin
            cfg_sent_reg <= cfg_now;
            req_reg <= ~req_reg;
         end
      end
   end

   ign_traffic_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_wr_en && cs_high && reg_addr == REG_TEST_MODE) |=>
      $stable(mode_reg)) else $error("write taken while port deselected");
   strap_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $past(strap_done_reg) |-> $stable(swing_reg) && $stable(strap_pat_reg))
      else $error("strap level changed after capture");
   swing_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(strap_done_reg) |-> ##1 reduced_swing == swing_reg)
      else $error("reduced swing output does not follow strap");

   // link side
   logic lrst_s1_reg, lrst_reg;
   logic req_s1_reg, req_s2_reg, req_s3_reg;
   logic [CFG_W-1:0] cfg_reg;
   logic [2:0] tick_reg;
   logic [3:0] bit_reg;
   logic word_sel_reg;
   logic [8:0] prbs9_reg;
   logic [22:0] prbs23_reg;
   logic [13:0] word_reg [LANES];
   logic [13:0] pat_val;
   always_ff @(posedge link_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lrst_s1_reg <= 1'b0;
         lrst_reg <= 1'b0;
      end
      else
      begin
         lrst_s1_reg <= 1'b1;
         lrst_reg <= lrst_s1_reg;
      end
   end

   wire c_strap = cfg_reg[44];
   wire c_lsb = cfg_reg[43];
   wire [1:0] c_res = cfg_reg[42:41];
   wire [2:0] c_phase_raw = cfg_reg[40:38];
   wire c_inv = cfg_reg[37];
   wire c_twos = cfg_reg[36];
   wire [3:0] c_mode = cfg_reg[35:32];
   wire [15:0] user_w1 = cfg_reg[31:16];
   wire [15:0] user_w2 = cfg_reg[15:0];
   wire [2:0] c_phase = (c_phase_raw > PHASE_MAX) ? PHASE_MAX : c_phase_raw;
   wire is_p9 = ~c_strap & (c_mode == TM_PRBS9);
   wire is_p23 = ~c_strap & (c_mode == TM_PRBS23);
   wire is_prbs = is_p9 | is_p23;
   wire pat_on = c_strap | ((c_mode != TM_OFF) & (c_mode <= TM_MIXED));
   wire [3:0] res_len = (c_res == RES_8) ? LEN_8 : (c_res == RES_10) ?
      LEN_10 : (c_res == RES_14) ? LEN_14 : LEN_12;
   wire [3:0] len = (is_prbs | c_strap) ? LEN_12 : res_len;
   wire [3:0] len_m1 = len - 4'h1;
   wire [13:0] ones = 14'((15'h1 << len) - 15'h1);
   wire [13:0] msb = 14'(15'h1 << len_m1);
   wire [13:0] sync_w = 14'((15'h1 << len[3:1]) - 15'h1);
   wire [13:0] mixed = (c_res == RES_8) ? MIX_8 : (c_res == RES_10) ? MIX_10 :
      (c_res == RES_14) ? MIX_14 : MIX_12;
   wire [13:0] user_r = 14'((word_sel_reg ? user_w2 : user_w1) >>
      (5'h10 - {1'b0, len}));
   wire fmt_pat = (c_mode == TM_MID) | (c_mode == TM_PFS) |
      (c_mode == TM_NFS);
   wire end_tick = (tick_reg == TICKS_PER_BIT - 3'h1);
   wire last_bit = (bit_reg >= len_m1);
   wire load = end_tick & last_bit;
   wire [3:0] pos = c_lsb ? (len_m1 - bit_reg) : bit_reg;
   wire [3:0] sel = 4'(4'hd - pos);
   wire p9_bit = prbs9_reg[8];
   wire p23_bit = ~prbs23_reg[22];
   wire prbs_bit = (is_p9 ? p9_bit : p23_bit) ^ (c_twos & (bit_reg == 4'h0));

   always_comb
   begin
      case (c_mode)
         TM_MID: pat_val = msb;
         TM_PFS: pat_val = ones;
         TM_NFS: pat_val = 14'h0000;
         TM_CHECK: pat_val = (word_sel_reg ? CHECK_B : CHECK_A) & ones;
         TM_WTOG: pat_val = word_sel_reg ? 14'h0000 : ones;
         TM_USER: pat_val = user_r;
         TM_BTOG: pat_val = CHECK_A & ones;
         TM_SYNC: pat_val = sync_w;
         TM_ONEHI: pat_val = msb;
         TM_MIXED: pat_val = mixed;
         default: pat_val = 14'h0000;
      endcase
   end

   always_ff @(posedge link_clk or negedge lrst_reg)
   begin
      if (!lrst_reg)
      begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
         ack_link_reg <= 1'b0;
         cfg_reg <= {4'h0, PHASE_RST, 38'h0000000000};
      end
      else
      begin
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         if (req_s2_reg != req_s3_reg)
         begin
            cfg_reg <= cfg_sent_reg;
            ack_link_reg <= req_s2_reg;
         end
      end
   end

   always_ff @(posedge link_clk or negedge lrst_reg)
   begin
      if (!lrst_reg)
      begin
         tick_reg <= 3'h0;
         bit_reg <= 4'h0;
         word_sel_reg <= 1'b0;
         sample_take <= 1'b0;
         frame_clock_out <= 1'b0;
         bit_clock_out <= 1'b0;
         prbs9_reg <= PRBS9_SEED;
         prbs23_reg <= PRBS23_SEED;
      end
      else
      begin
         tick_reg <= end_tick ? 3'h0 : tick_reg + 3'h1;
         if (end_tick) bit_reg <= last_bit ? 4'h0 : bit_reg + 4'h1;
         if (load) word_sel_reg <= ~word_sel_reg;
         sample_take <= load;
         if (tick_reg == 3'h0)
            frame_clock_out <= (bit_reg < {1'b0, len[3:1]});
         if (tick_reg == c_phase)
            bit_clock_out <= ~bit_clock_out;
         if (!is_p9)
            prbs9_reg <= PRBS9_SEED;
         else if (tick_reg == 3'h0)
            prbs9_reg <= {prbs9_reg[7:0], prbs9_reg[8] ^ prbs9_reg[4]};
         if (!is_p23)
            prbs23_reg <= PRBS23_SEED;
         else if (tick_reg == 3'h0)
            prbs23_reg <= {prbs23_reg[21:0],
               prbs23_reg[22] ^ prbs23_reg[17]};
      end
   end

   genvar l;
   generate
      for (l = 0; l < LANES; l++)
      begin : g_lane
         wire [11:0] d = sample_data[l*DATA_W +: DATA_W];
         wire [13:0] d_r = (len == LEN_14) ? {d, 2'b00} :
            14'(d >> (4'hc - len));
         wire d_fmt = c_twos & ~c_strap & (~pat_on | fmt_pat);
         wire [13:0] sel_r = c_strap ? {2'b00, STRAP_WORD} :
            pat_on ? pat_val : d_r;
         wire [13:0] fmt_r = sel_r ^ (d_fmt ? msb : 14'h0000);
         wire [13:0] left = 14'(fmt_r << (4'he - len));
         wire bit_v = is_prbs ? prbs_bit : word_reg[l][sel];
         always_ff @(posedge link_clk or negedge lrst_reg)
         begin
            if (!lrst_reg)
            begin
               word_reg[l] <= 14'h0000;
               data_out[l] <= 1'b0;
            end
            else
            begin
               if (load) word_reg[l] <= left;
               if (tick_reg == 3'h0) data_out[l] <= bit_v ^ c_inv;
            end
         end
      end
   endgenerate

   bclk_phase_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (tick_reg == c_phase && $stable(c_phase)) |=>
      bit_clock_out != $past(bit_clock_out))
      else $error("bit clock missed its phase tick");
   bclk_hold_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (tick_reg != c_phase) |=> $stable(bit_clock_out))
      else $error("bit clock moved off its phase tick");
   word_len_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (load && len == LEN_8 && $stable(len)) |=> (!load)[*8])
      else $error("8-bit word shorter than expected");
   stuff_zero_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (load && len == LEN_14 && !pat_on) |=> word_reg[0][1:0] == 2'b00)
      else $error("14-bit word lacks trailing zeros");
   frame_start_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (tick_reg == 3'h0 && bit_reg == 4'h0) |=> frame_clock_out)
      else $error("frame clock low at word start");
   p9_seed_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      !is_p9 |=> prbs9_reg == PRBS9_SEED)
      else $error("prbs9 not reseeded");
   invert_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (tick_reg == 3'h0 && !is_prbs) |=>
      data_out[0] == ($past(word_reg[0][sel]) ^ $past(c_inv)))
      else $error("lane bit or inversion wrong");
   strap_word_a: assert property (@(posedge link_clk) disable iff (!lrst_reg)
      (load && c_strap) |=> word_reg[0][13:2] == STRAP_WORD)
      else $error("strap pattern word wrong");
endmodule : lotp_top

// ==== common/lotp_pkg.sv ====
/*
 lotp_pkg: constants, register offsets, field positions, reset values and
 the test mode encoding of the lane formatter and test pattern generator.
 assumes nothing of its surroundings.
*/
package lotp_pkg;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_TEST_MODE = 8'h0d;
   localparam logic [7:0] REG_OUT_MODE = 8'h14;
   localparam logic [7:0] REG_PHASE = 8'h16;
   localparam logic [7:0] REG_USER_A = 8'h19;
   localparam logic [7:0] REG_USER_B = 8'h1a;
   localparam logic [7:0] REG_USER_C = 8'h1b;
   localparam logic [7:0] REG_USER_D = 8'h1c;
   localparam logic [7:0] REG_RES = 8'h21;
   localparam int OUT_MODE_TWOS_BIT = 0;
   localparam int OUT_MODE_INV_BIT = 2;
   localparam int RES_LSB_FIRST_BIT = 2;
   localparam logic [3:0] TEST_MODE_RST = 4'h0;
   localparam logic [2:0] PHASE_RST = 3'h3;
   localparam logic [2:0] PHASE_MAX = 3'h5;
   localparam logic [1:0] RES_RST = 2'h0;
   localparam logic [7:0] USER_RST = 8'h00;
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_8 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_14 = 2'h3;
   localparam logic [3:0] LEN_8 = 4'h8;
   localparam logic [3:0] LEN_10 = 4'ha;
   localparam logic [3:0] LEN_12 = 4'hc;
   localparam logic [3:0] LEN_14 = 4'he;
   localparam int DATA_W = 12;
   localparam int WORD_MAX = 14;
   localparam logic [2:0] TICKS_PER_BIT = 3'h6;
   localparam logic [1:0] STRAP_DLY = 2'h2;
   localparam logic [8:0] PRBS9_SEED = 9'h0df;
   localparam logic [22:0] PRBS23_SEED = 23'h29b80a;
   localparam logic [13:0] MIX_8 = 14'h00a3;
   localparam logic [13:0] MIX_10 = 14'h0263;
   localparam logic [13:0] MIX_12 = 14'h0a33;
   localparam logic [13:0] MIX_14 = 14'h2867;
   localparam logic [13:0] CHECK_A = 14'h2aaa;
   localparam logic [13:0] CHECK_B = 14'h1555;
   localparam logic [11:0] STRAP_WORD = 12'h800;
   typedef enum logic [3:0] {
      TM_OFF = 4'b0000,
      TM_MID = 4'b0001,
      TM_PFS = 4'b0010,
      TM_NFS = 4'b0011,
      TM_CHECK = 4'b0100,
      TM_PRBS23 = 4'b0101,
      TM_PRBS9 = 4'b0110,
      TM_WTOG = 4'b0111,
      TM_USER = 4'b1000,
      TM_BTOG = 4'b1001,
      TM_SYNC = 4'b1010,
      TM_ONEHI = 4'b1011,
      TM_MIXED = 4'b1100
   } lotp_mode_t;
endpackage : lotp_pkg

// ==== tb/lotp_capture_model.sv ====
/*
 lotp_capture_model: receiver that captures lanes 0 and 1 mid bit.
 assumes data and frame clock change only at tick 0 of a bit.
*/
`timescale 1ns/1ps
module lotp_capture_model #(
   parameter int LANES = 4
) (
   input wire logic link_clk,
   input wire logic resetn,
   input wire logic [LANES-1:0] data_out,
   input wire logic frame_clock_out,
   input wire logic bit_clock_out,
   output logic [15:0] word0,
   output logic [15:0] word1,
   output logic [4:0] wlen,
   output logic [2:0] bc_tick,
   output int word_cnt
);
   logic [15:0] sh0, sh1;
   logic [4:0] nbits;
   logic [2:0] tick;
   logic fr_q, bc_q;
   wire rise = frame_clock_out & ~fr_q;
   wire [2:0] tick_now = rise ? 3'h0 : (tick == 3'h5 ? 3'h0 : tick + 3'h1);
   always_ff @(posedge link_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         {sh0, sh1, word0, word1} <= '0;
         {nbits, wlen, tick, bc_tick, fr_q, bc_q} <= '0;
         word_cnt <= 0;
      end
      else
      begin
         fr_q <= frame_clock_out;
         bc_q <= bit_clock_out;
         tick <= tick_now;
         if (bit_clock_out != bc_q)
            bc_tick <= tick_now;
         if (rise)
         begin
            word0 <= sh0;
            word1 <= sh1;
            wlen <= nbits;
            word_cnt <= word_cnt + 1;
            {sh0, sh1, nbits} <= '0;
         end
         else if (tick_now == 3'h3)
         begin
            sh0 <= {sh0[14:0], data_out[0]};
            sh1 <= {sh1[14:0], data_out[1]};
            nbits <= nbits + 5'h1;
         end
      end
   end
endmodule : lotp_capture_model

// ==== tb/lotp_top_tb.sv ====
/*
 lotp_top_tb: self-checking bench of the lane formatter.
 assumes the capture model on lanes 0 and 1 and constant samples.
*/
`timescale 1ns/1ps
module lotp_top_tb;
   import lotp_pkg::*;
   localparam int LANES = 4;
   localparam logic [11:0] S0 = 12'hb34;
   localparam logic [11:0] S1 = 12'h6c1;
   logic ref_clk, link_clk, resetn, port_select_n, sd_pin, sc_pin;
   logic reg_wr_en, reduced_swing, sample_take, frame_clock_out;
   logic bit_clock_out;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data, d;
   logic [LANES*DATA_W-1:0] sample_data;
   logic [LANES-1:0] data_out;
   logic [15:0] word0, word1, w;
   logic [4:0] wlen, len;
   logic [2:0] bc_tick;
   int word_cnt;
   int num_errors = 0;
   int checks = 0;
   lotp_top #(.LANES(LANES)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .link_clk(link_clk), .port_select_n(port_select_n),
      .serial_data_or_swing_pin(sd_pin),
      .serial_clock_or_pattern_pin(sc_pin), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_rd_data(reg_rd_data), .reduced_swing(reduced_swing),
      .sample_data(sample_data), .sample_take(sample_take),
      .data_out(data_out), .frame_clock_out(frame_clock_out),
      .bit_clock_out(bit_clock_out));
   lotp_capture_model #(.LANES(LANES)) rx (.link_clk(link_clk),
      .resetn(resetn), .data_out(data_out),
      .frame_clock_out(frame_clock_out), .bit_clock_out(bit_clock_out),
      .word0(word0), .word1(word1), .wlen(wlen), .bc_tick(bc_tick),
      .word_cnt(word_cnt));
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #3.7;
      forever #24 link_clk = ~link_clk;
   end
   task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr_data = v;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      repeat (2) @(negedge ref_clk);
      v = reg_rd_data;
   endtask : rd
   task automatic grab(output logic [15:0] g, output logic [4:0] l);
      int c0;
      c0 = word_cnt;
      for (int i = 0; i < 2000 && word_cnt == c0; i++)
         @(negedge ref_clk);
      if (word_cnt == c0)
         num_errors++;
      g = word0;
      l = wlen;
   endtask : grab
   task automatic look(input string n, input logic [15:0] e,
      input logic [4:0] el);
      repeat (3) grab(w, len);
      grab(w, len);
      chk(n, w, e);
      chk(n, {11'h0, len}, {11'h0, el});
   endtask : look
   task automatic pair(input logic [3:0] m, input logic [11:0] a,
      input logic [11:0] b);
      logic [15:0] w2;
      wr(REG_TEST_MODE, {4'h0, m});
      repeat (3) grab(w, len);
      grab(w2, len);
      chk("pair second", (w == a) ? w2 : w, b);
      chk("pair first", (w == a) ? w : w2, a);
   endtask : pair
   task automatic prbs(input logic [3:0] m, input int ta, input int tb,
      input logic inv);
      logic [47:0] s;
      int bad;
      bad = 0;
      wr(REG_RES, {6'h0, RES_14});
      wr(REG_TEST_MODE, {4'h0, m});
      repeat (3) grab(w, len);
      for (int k = 0; k < 4; k++)
      begin
         grab(w, len);
         s[47-12*k -: 12] = w[11:0];
      end
      chk("prbs len", {11'h0, len}, 16'hc);
      for (int n = ta; n < 48; n++)
         if (s[47-n] !== (s[47-n+ta] ^ s[47-n+tb] ^ inv))
            bad++;
      chk("prbs stream", bad[15:0], 16'h0);
      wr(REG_RES, {6'h0, RES_12});
   endtask : prbs
   task automatic t_regs;
      rd(REG_PHASE, d);
      chk("phase reset", {8'h0, d}, {13'h0, PHASE_RST});
      rd(REG_TEST_MODE, d);
      chk("mode reset", {8'h0, d}, 16'h0);
      wr(REG_USER_A, 8'h5a);
      rd(REG_USER_A, d);
      chk("user a", {8'h0, d}, 16'h5a);
      rd(8'h30, d);
      chk("unmapped", {8'h0, d}, 16'h0);
      rd(REG_STATUS, d);
      chk("straps", {14'h0, d[1:0]}, 16'h0);
   endtask : t_regs
   task automatic t_format;
      look("msb first", {4'h0, S0}, 5'd12);
      chk("lane1", word1, {4'h0, S1});
      chk("bit clk", {13'h0, bc_tick}, 16'h3);
      wr(REG_RES, 8'h04);
      look("lsb first", {4'h0, {<<{S0}}}, 5'd12);
      wr(REG_OUT_MODE, 8'h04);
      look("inv lsb", {4'h0, ~{<<{S0}}}, 5'd12);
      wr(REG_RES, 8'h00);
      look("inv", {4'h0, ~S0}, 5'd12);
      wr(REG_OUT_MODE, 8'h01);
      look("twos", {4'h0, S0 ^ 12'h800}, 5'd12);
      wr(REG_OUT_MODE, 8'h00);
      wr(REG_RES, {6'h0, RES_8});
      look("res8", {8'h0, S0[11:4]}, 5'd8);
      wr(REG_RES, {6'h0, RES_10});
      look("res10", {6'h0, S0[11:2]}, 5'd10);
      wr(REG_RES, {6'h0, RES_14});
      look("res14", {2'h0, S0, 2'b00}, 5'd14);
      wr(REG_RES, {6'h0, RES_12});
      wr(REG_PHASE, 8'h01);
      look("phase1", {4'h0, S0}, 5'd12);
      chk("phase1 tick", {13'h0, bc_tick}, 16'h1);
      wr(REG_PHASE, 8'h07);
      repeat (3) grab(w, len);
      chk("phase clamp", {13'h0, bc_tick}, 16'h5);
      wr(REG_PHASE, 8'h03);
   endtask : t_format
   task automatic t_patterns;
      logic [3:0] m[7] = '{TM_MID, TM_PFS, TM_NFS, TM_BTOG, TM_SYNC,
         TM_ONEHI, TM_MIXED};
      logic [11:0] e[7] = '{12'h800, 12'hfff, 12'h000, 12'haaa, 12'h03f,
         12'h800, 12'ha33};
      for (int i = 0; i < 7; i++)
      begin
         wr(REG_TEST_MODE, {4'h0, m[i]});
         look("single", {4'h0, e[i]}, 5'd12);
         grab(w, len);
         chk("repeat", w, {4'h0, e[i]});
      end
      wr(REG_RES, {6'h0, RES_8});
      look("mixed8", 16'ha3, 5'd8);
      wr(REG_RES, {6'h0, RES_12});
      pair(TM_CHECK, 12'haaa, 12'h555);
      pair(TM_WTOG, 12'hfff, 12'h000);
      wr(REG_USER_A, 8'h12);
      wr(REG_USER_B, 8'h34);
      wr(REG_USER_C, 8'h56);
      wr(REG_USER_D, 8'h78);
      wr(REG_OUT_MODE, 8'h01);
      pair(TM_USER, 12'h123, 12'h567);
      wr(REG_TEST_MODE, {4'h0, TM_MID});
      look("mid twos", 16'h0, 5'd12);
      wr(REG_OUT_MODE, 8'h00);
      prbs(TM_PRBS9, 9, 5, 1'b0);
      prbs(TM_PRBS23, 23, 18, 1'b1);
      wr(REG_TEST_MODE, 8'h00);
   endtask : t_patterns
   task automatic t_select;
      @(negedge ref_clk);
      port_select_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      wr(REG_TEST_MODE, {4'h0, TM_PFS});
      port_select_n = 1'b0;
      rd(REG_TEST_MODE, d);
      chk("ignored", {8'h0, d}, 16'h0);
   endtask : t_select
   task automatic t_straps;
      @(negedge ref_clk);
      resetn = 1'b0;
      port_select_n = 1'b1;
      sd_pin = 1'b1;
      sc_pin = 1'b1;
      repeat (16) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (10) @(negedge ref_clk);
      sd_pin = 1'b0;
      sc_pin = 1'b0;
      chk("swing", {15'h0, reduced_swing}, 16'h1);
      rd(REG_STATUS, d);
      chk("strap bits", {14'h0, d[1:0]}, 16'h3);
      look("strap word", 16'h800, 5'd12);
      chk("strap lane1", word1, 16'h800);
      chk("swing tick", {13'h0, bc_tick}, 16'h3);
      chk("swing held", {15'h0, reduced_swing}, 16'h1);
   endtask : t_straps
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #900000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      resetn = 1'b0;
      port_select_n = 1'b0;
      {sd_pin, sc_pin, reg_wr_en} = 3'b000;
      reg_addr = 8'h00;
      reg_wr_data = 8'h00;
      sample_data = {S1, S1, S1, S0};
      repeat (16) @(negedge ref_clk);
      resetn = 1'b1;
      t_regs();
      t_format();
      t_patterns();
      t_select();
      t_straps();
      print_verdict();
   end
endmodule : lotp_top_tb
